// ### hdl/au_pkg.sv
// Constants, types and bus carrier shared by the arithmetic unit
package au_pkg;

  // Register addresses on the plain register port
  localparam logic [2:0] ADDR_B0   = 3'h0;  // Operand byte 0 (lsb)
  localparam logic [2:0] ADDR_B1   = 3'h1;  // Operand byte 1
  localparam logic [2:0] ADDR_B2   = 3'h2;  // Operand byte 2
  localparam logic [2:0] ADDR_B3   = 3'h3;  // Operand byte 3
  localparam logic [2:0] ADDR_B4   = 3'h4;  // Operand byte 4
  localparam logic [2:0] ADDR_B5   = 3'h5;  // Operand byte 5
  localparam logic [2:0] ADDR_CTRL = 3'h6;  // Arithmetic control

  // Control register field positions
  localparam int CTRL_ERR_BIT = 7;  // Error flag, read only
  localparam int CTRL_OV_BIT  = 6;  // Overflow flag, read only
  localparam int CTRL_DIR_BIT = 5;  // Shift direction, 1 is right
  localparam int CTRL_CNT_MSB = 4;  // Shift count top bit

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;  // Operand bytes
  localparam logic [4:0] RST_CNT  = 5'h00;  // Shift count
  localparam logic [4:0] RST_TIM  = 5'h00;  // Latency timer

  // Latencies in clock cycles
  localparam logic [4:0] LAT_DIV32      = 5'h11;  // 17 cycles
  localparam logic [4:0] LAT_DIV16      = 5'h09;  // 9 cycles
  localparam logic [4:0] LAT_MUL        = 5'h0b;  // 11 cycles
  localparam logic [4:0] LAT_SHIFT_BASE = 5'h02;  // Plus half the count
  localparam logic [4:0] LAT_NORM_BASE  = 5'h03;  // Plus half the shifts

  // Arithmetic limits
  localparam logic [31:0] MUL_OV_LIMIT  = 32'h0000ffff;  // Largest clean product
  localparam logic [31:0] DIV_ZERO_QUOT = 32'hffffffff;  // Quotient on zero divisor

  // Sequencer states
  typedef enum logic [3:0] {
    AU_ST_IDLE = 4'b0001,
    AU_ST_LOAD = 4'b0010,
    AU_ST_RUN  = 4'b0100,
    AU_ST_DONE = 4'b1000
  } au_state_t;

  // Operations
  typedef enum logic [4:0] {
    AU_OP_DIV32 = 5'b00001,
    AU_OP_DIV16 = 5'b00010,
    AU_OP_MUL   = 5'b00100,
    AU_OP_SHIFT = 5'b01000,
    AU_OP_NORM  = 5'b10000
  } au_op_t;

  // Register port request
  typedef struct packed {
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
    logic [2:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } au_req_t;

endpackage

// ### hdl/au_arith_unit.sv
// Multiply, divide, shift and normalize co-processor with byte registers
//
// Contract
// - Byte five or control write launches operation
// - Bytes two/three written selects 32/16 divide
// - Byte four divides 16/16, byte one multiplies
// - Unit runs alone while processor continues
// - Divide 17/9 clocks, multiply 11 clocks
// - Shift takes 3 to 18 clocks
// - Normalize takes 3 to 19 clocks
// - Final result read ends whole calculation
// - Normalize shifts left until top bit set
// - Normalize leaves shift total in count field
// - Bit five direction, bits four-zero count
// - Shifts bring in zeros at vacated end
// - Byte zero write arms, final read disarms
// - Write during execution sets error flag
// - Armed read during execution sets error only
// - Error flag cleared only by control read
// - Overflow on zero divisor, big product, normalized
// - Other operations clear overflow; hardware only
// - Control: overflow bit6, direction bit5, count
// - Zero count normalizes, nonzero count shifts
`timescale 1ns/100ps

module au_arith_unit (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire au_pkg::au_req_t req,
  output logic [7:0]           rd_data,
  output logic                 busy
);

  // Leading zero count of a word, 31 for an all-zero word
  function automatic logic [4:0] au_lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       found;
    n     = 5'h1f;
    found = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (!found && v[i])
      begin
        n     = 5'(31 - i);
        found = 1'b1;
      end
    end
    return n;
  endfunction

  // Storage
  logic [7:0]        md [0:5];    // Operand and result bytes
  logic              err;         // Improper operation flag
  logic              ov;          // Overflow flag
  logic              dir;         // Shift direction
  logic [4:0]        cnt;         // Shift count field
  au_pkg::au_state_t state;       // Sequencer state
  au_pkg::au_op_t    op;          // Operation in progress
  logic [4:0]        timer;       // Cycles left in execution
  logic              armed;       // Error detection armed
  logic              f_b1;        // Byte 1 written after any byte 4
  logic              f_b23;       // Byte 2 or 3 written in this load
  logic              f_b4;        // Byte 4 written after any byte 1

  // Address decode, one bit per register
  wire [6:0] wr_sel   = req.wr ? (7'h01 << req.addr) : 7'h00;
  wire [6:0] rd_sel   = req.rd ? (7'h01 << req.addr) : 7'h00;
  wire       any_wr   = |wr_sel;              // Write to any register
  wire       byte_rd  = |rd_sel[5:0];         // Read of an operand byte
  wire       ctrl_wr  = wr_sel[6];            // Control register write
  wire       ctrl_rd  = rd_sel[6];            // Control register read

  // State decode
  wire st_load = (state == au_pkg::AU_ST_LOAD);
  wire st_run  = (state == au_pkg::AU_ST_RUN);
  wire st_done = (state == au_pkg::AU_ST_DONE);

  // Operand views
  wire [31:0] lo32   = {md[3], md[2], md[1], md[0]};  // Dividend or shift word
  wire [15:0] hi16   = {md[5], md[4]};                // Divisor or second factor
  wire        div0   = (hi16 == 16'h0000);            // Zero divisor
  wire [4:0]  lz     = au_lead_zeros(lo32);           // Normalize distance

  // Operation chosen by a byte five write
  wire b5_is_div32 = f_b23;
  wire b5_is_div16 = !f_b23 && f_b4;
  wire b5_is_mul   = !f_b23 && f_b1;
  wire b5_has_op   = f_b23 || f_b4 || f_b1;

  // Launch conditions, from loading or as a restart
  wire in_seq      = st_load || st_run;
  wire launch_b5   = in_seq && wr_sel[5] && b5_has_op;
  wire launch_ctrl = in_seq && ctrl_wr;
  wire launch      = launch_b5 || launch_ctrl;

  // Zero count picks normalize
  wire [4:0] wr_cnt  = req.wdata[au_pkg::CTRL_CNT_MSB:0];
  wire       is_norm = (wr_cnt == 5'h00);

  // Operation to latch at launch
  au_pkg::au_op_t launch_op;
  always_comb
  begin
    // Byte five write picks a divide or multiply
    if (launch_b5)
    begin
      if (b5_is_div32)
        launch_op = au_pkg::AU_OP_DIV32;
      else if (b5_is_div16)
        launch_op = au_pkg::AU_OP_DIV16;
      else
        launch_op = au_pkg::AU_OP_MUL;
    end
    // Control write picks shift or normalize
    else if (is_norm)
      launch_op = au_pkg::AU_OP_NORM;
    else
      launch_op = au_pkg::AU_OP_SHIFT;
  end

  // Half of a count plus one, for the shift and normalize latencies
  wire [5:0] sh_half = (6'(wr_cnt) + 6'h01) >> 1;
  wire [5:0] nm_half = (6'(lz) + 6'h01) >> 1;

  // Latency loaded at launch
  logic [4:0] launch_lat;
  always_comb
  begin
    case (launch_op)
      au_pkg::AU_OP_DIV32: launch_lat = au_pkg::LAT_DIV32;
      au_pkg::AU_OP_DIV16: launch_lat = au_pkg::LAT_DIV16;
      au_pkg::AU_OP_MUL:   launch_lat = au_pkg::LAT_MUL;
      au_pkg::AU_OP_SHIFT: launch_lat = sh_half[4:0] + au_pkg::LAT_SHIFT_BASE;
      au_pkg::AU_OP_NORM:  launch_lat = nm_half[4:0] + au_pkg::LAT_NORM_BASE;
      default:             launch_lat = au_pkg::LAT_MUL;
    endcase
  end

  // Arithmetic, evaluated on the stable operands during execution
  wire [31:0] q32  = div0 ? au_pkg::DIV_ZERO_QUOT : lo32 / {16'h0000, hi16};
  wire [31:0] r32  = div0 ? lo32 : lo32 % {16'h0000, hi16};
  wire [15:0] q16  = div0 ? 16'hffff : lo32[15:0] / hi16;
  wire [15:0] r16  = div0 ? lo32[15:0] : lo32[15:0] % hi16;
  wire [31:0] prod = {16'h0000, lo32[15:0]} * {16'h0000, hi16};
  // Zeros fill the vacated end of the word
  wire [31:0] shv  = dir ? (lo32 >> cnt) : (lo32 << cnt);
  wire [31:0] nrm  = lo32 << lz;

  // Result selection
  logic [31:0] res_lo;   // New bytes 0..3
  logic [15:0] res_hi;   // New bytes 4..5
  logic        res_ov;   // New overflow flag
  logic [4:0]  res_cnt;  // New count field
  always_comb
  begin
    res_lo  = lo32;
    res_hi  = hi16;
    res_ov  = 1'b0;  // Clean operations clear overflow
    res_cnt = cnt;
    case (op)
      au_pkg::AU_OP_DIV32:
      begin
        res_lo = q32;
        res_hi = r32[15:0];
        res_ov = div0;
      end
      au_pkg::AU_OP_DIV16:
      begin
        res_lo = {lo32[31:16], q16};
        res_hi = r16;
        res_ov = div0;
      end
      au_pkg::AU_OP_MUL:
      begin
        res_lo = prod;
        res_ov = (prod > au_pkg::MUL_OV_LIMIT);
      end
      au_pkg::AU_OP_SHIFT:
      begin
        res_lo = shv;
      end
      au_pkg::AU_OP_NORM:
      begin
        res_lo  = nrm;
        res_cnt = lz;        // Shifts performed
        res_ov  = lo32[31];  // Already normalized at start
      end
      default:
      begin
        res_lo = lo32;
      end
    endcase
  end

  // Execution finishes when the timer runs out with no interfering write
  wire commit = st_run && (timer == 5'h01) && !any_wr;

  // Final read of the result ends the calculation
  wire op_div     = (op == au_pkg::AU_OP_DIV32) || (op == au_pkg::AU_OP_DIV16);
  wire final_rd   = st_done && (op_div ? rd_sel[5] : rd_sel[3]);

  // Error sources during execution
  wire err_wr  = st_run && any_wr;
  wire err_rd  = st_run && armed && byte_rd;
  wire err_set = err_wr || err_rd;

  // Next state
  au_pkg::au_state_t next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      au_pkg::AU_ST_IDLE,
      au_pkg::AU_ST_DONE:
      begin
        if (wr_sel[0])
          next_state = au_pkg::AU_ST_LOAD;
        else if (final_rd)
          next_state = au_pkg::AU_ST_IDLE;
      end
      au_pkg::AU_ST_LOAD:
      begin
        if (launch)
          next_state = au_pkg::AU_ST_RUN;
      end
      au_pkg::AU_ST_RUN:
      begin
        // A write interrupts; a launching write restarts
        if (launch)
          next_state = au_pkg::AU_ST_RUN;
        else if (any_wr)
          next_state = au_pkg::AU_ST_LOAD;
        else if (commit)
          next_state = au_pkg::AU_ST_DONE;
      end
      default:
      begin
        next_state = au_pkg::AU_ST_IDLE;
      end
    endcase
  end

  // Next value of the error flag; a new event beats the clear
  wire next_err = err_set || (err && !ctrl_rd);

  // Next value of the armed flag
  wire next_armed = wr_sel[0] || (armed && !final_rd);

  // Control word and register read data for the registered read port
  wire [7:0] ctrl_word = {err, ov, dir, cnt};
  wire [7:0] rd_mux    = ctrl_rd ? ctrl_word :
                         (req.addr <= au_pkg::ADDR_B5) ? md[req.addr] : 8'h00;

  // Sequencer, timer and operation
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= au_pkg::AU_ST_IDLE;
      busy  <= 1'b0;
      op    <= au_pkg::AU_OP_MUL;
      timer <= au_pkg::RST_TIM;
    end
    else
    begin
      state <= next_state;
      // Registered copy of the running state, so busy leaves a flop
      busy  <= (next_state == au_pkg::AU_ST_RUN);
      if (launch)
      begin
        op    <= launch_op;
        timer <= launch_lat;
      end
      else if (st_run && timer != 5'h00)
        timer <= timer - 5'h01;   // Runs without the processor
    end
  end

  // Load order tracking for operation selection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      f_b1  <= 1'b0;
      f_b23 <= 1'b0;
      f_b4  <= 1'b0;
    end
    else if (wr_sel[0])
    begin
      // Byte zero opens a fresh sequence
      f_b1  <= 1'b0;
      f_b23 <= 1'b0;
      f_b4  <= 1'b0;
    end
    else
    begin
      // The later of bytes 1 and 4 picks multiply or short divide
      f_b1  <= wr_sel[1] || (f_b1 && !wr_sel[4]);
      f_b23 <= f_b23 || wr_sel[2] || wr_sel[3];
      f_b4  <= wr_sel[4] || (f_b4 && !wr_sel[1]);
    end
  end

  // Operand bytes: software writes, or results at the end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 6; i++)
        md[i] <= au_pkg::RST_BYTE;
    end
    else if (commit)
    begin
      md[0] <= res_lo[7:0];
      md[1] <= res_lo[15:8];
      md[2] <= res_lo[23:16];
      md[3] <= res_lo[31:24];
      md[4] <= res_hi[7:0];
      md[5] <= res_hi[15:8];
    end
    else
    begin
      for (int i = 0; i < 6; i++)
        if (wr_sel[i])
          md[i] <= req.wdata;
    end
  end

  // Control fields; overflow is not writable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir <= 1'b0;
      cnt <= au_pkg::RST_CNT;
      ov  <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      dir <= req.wdata[au_pkg::CTRL_DIR_BIT];
      cnt <= wr_cnt;
    end
    else if (commit)
    begin
      cnt <= res_cnt;
      ov  <= res_ov;
    end
  end

  // Error and arming flags
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err   <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      err   <= next_err;
      armed <= next_armed;
    end
  end

  // Read port: data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= 8'h00;
    else
      rd_data <= req.rd ? rd_mux : 8'h00;
  end

endmodule

// ### tb/au_cpu_model.sv
// Register-port master standing in for the processor core
`timescale 1ns/100ps

module au_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output au_pkg::au_req_t req
);
  // Bus idle from time zero
  initial req = '0;

  // One-cycle write; stays up until the next request replaces it
  task automatic w(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
  endtask

  // One-cycle read; data taken in the cycle after the strobe
  task automatic r(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    v = rd_data;
  endtask

  // Release the bus for one edge
  task automatic idle();
    @(posedge clk);
    req <= '0;
    #1;
  endtask
endmodule

// ### tb/au_arith_unit_asserts.sv
// Port-level timing checks for the arithmetic unit
`timescale 1ns/100ps

module au_arith_unit_asserts (
  input wire logic            clk,
  input wire logic            arst_n,
  input wire au_pkg::au_req_t req,
  input wire logic [7:0]      rd_data,
  input wire logic            busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Write to one register
  sequence wr_at(a);
    req.wr && req.addr == a;
  endsequence
  // Load orders that pick multiply and both divides
  sequence mul_load;
    wr_at(3'h0) ##1 wr_at(3'h4) ##1 wr_at(3'h1) ##1 wr_at(3'h5);
  endsequence
  sequence div16_load;
    wr_at(3'h0) ##1 wr_at(3'h1) ##1 wr_at(3'h4) ##1 wr_at(3'h5);
  endsequence
  sequence div32_load;
    wr_at(3'h0) ##1 wr_at(3'h1) ##1 wr_at(3'h2) ##1 wr_at(3'h3) ##1 wr_at(3'h4)
      ##1 wr_at(3'h5);
  endsequence
  // Two control reads with a quiet cycle between
  sequence ctl_rd_twice;
    (req.rd && req.addr == 3'h6 && !busy) ##1 !busy ##1 (req.rd && req.addr == 3'h6);
  endsequence

  rd_idle_zero_a: assert property (!req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (req.rd && req.addr == 3'h7 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  busy_cause_a: assert property (
    !busy && !(req.wr && (req.addr == 3'h5 || req.addr == 3'h6)) |=> !busy)
    else $error("busy rose without a launch");
  mul_lat_a: assert property (mul_load |=> busy [*8] ##1 busy [*3] ##1 !busy)
    else $error("multiply run length wrong");
  div16_lat_a: assert property (div16_load |=> busy [*8] ##1 busy ##1 !busy)
    else $error("short divide run length wrong");
  div32_lat_a: assert property (
    div32_load |=> busy [*8] ##1 busy [*8] ##1 busy ##1 !busy)
    else $error("long divide run length wrong");
  shift_one_a: assert property (
    wr_at(3'h3) ##1 (wr_at(3'h6) && req.wdata[4:0] == 5'h01) |=> busy [*3] ##1 !busy)
    else $error("single shift run length wrong");
  err_clear_a: assert property (ctl_rd_twice |=> !rd_data[7])
    else $error("error flag survived a control read");
endmodule

bind au_arith_unit au_arith_unit_asserts u_chk (
  .clk     (clk),
  .arst_n  (arst_n),
  .req     (req),
  .rd_data (rd_data),
  .busy    (busy)
);

// ### tb/test_au_arith_unit.sv
// Self-checking bench for the arithmetic unit
`timescale 1ns/100ps

module test_au_arith_unit;
  logic            clk;           // 50 MHz core clock
  logic            arst_n;        // Reset, active low
  au_pkg::au_req_t req;           // Register port from the core model
  logic [7:0]      rd_data;       // Read answer
  logic            busy;          // Run in progress
  int              n_fail;        // Mismatches
  int              total_checks;  // Comparisons made
  logic [7:0]      d;             // Last read value

  initial clk = 1'b0;
  always #10 clk = ~clk;

  au_cpu_model cpu (.clk(clk), .rd_data(rd_data), .req(req));
  au_arith_unit DUT (.clk(clk), .arst_n(arst_n), .req(req), .rd_data(rd_data),
                     .busy(busy));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read one register and compare
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    cpu.r(a, d);
    chk($sformatf("reg%0d", a), {24'h0, e}, {24'h0, d});
  endtask

  // Read bytes 0..3, top byte last
  task automatic rq(input logic [31:0] e);
    for (int i = 0; i < 4; i++)
      rc(i[2:0], e[8*i +: 8]);
  endtask

  // Compare error and overflow flags
  task automatic cf(input logic [1:0] e);
    cpu.r(3'h6, d);
    chk("flags", {30'h0, e}, {30'h0, d[7:6]});
  endtask

  // Load a word, low byte first
  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      cpu.w(i[2:0], v[8*i +: 8]);
  endtask

  // Count cycles until busy drops
  task automatic lat(input int l);
    int n;
    n = 0;
    cpu.idle();
    while (busy === 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("latency", l, n);
  endtask

  task automatic t_reset();
    rc(3'h0, 8'h00);
    rc(3'h6, 8'h00);
    cpu.w(3'h7, 8'h5a);
    rc(3'h7, 8'h00);
  endtask

  task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = {16'h0, a} * {16'h0, b};
    cpu.w(3'h0, a[7:0]);
    cpu.w(3'h4, b[7:0]);
    cpu.w(3'h1, a[15:8]);
    cpu.w(3'h5, b[15:8]);
    lat(11);
    rq(p);
    cf({1'b0, p > 32'h0000ffff});
  endtask

  task automatic t_div16(input logic [15:0] x, input logic [15:0] y);
    logic [15:0] q;
    logic [15:0] m;
    q = (y != 16'h0) ? x / y : 16'hffff;
    m = (y != 16'h0) ? x % y : x;
    cpu.w(3'h0, x[7:0]);
    cpu.w(3'h1, x[15:8]);
    cpu.w(3'h4, y[7:0]);
    cpu.w(3'h5, y[15:8]);
    lat(9);
    rc(3'h0, q[7:0]);
    rc(3'h1, q[15:8]);
    rc(3'h4, m[7:0]);
    rc(3'h5, m[15:8]);
    cf({1'b0, y == 16'h0});
  endtask

  task automatic t_div32(input logic [31:0] x, input logic [15:0] y, input logic rd_early);
    logic [31:0] q;
    q = x / {16'h0, y};
    ld(x);
    cpu.w(3'h4, y[7:0]);
    cpu.w(3'h5, y[15:8]);
    if (rd_early)
    begin
      cpu.r(3'h0, d);
      lat(15);
    end
    else
      lat(17);
    rq(q);
    rc(3'h4, 8'(x % {16'h0, y}));
    rc(3'h5, 8'((x % {16'h0, y}) >> 8));
    cf({rd_early, 1'b0});
    cf(2'b00);
  endtask

  task automatic t_shift(input logic dir, input logic [4:0] c);
    logic [31:0] v;
    v = 32'h81234561;
    ld(v);
    cpu.w(3'h6, {2'b00, dir, c});
    lat((int'(c) + 1) / 2 + 2);
    rq(dir ? v >> c : v << c);
    cf(2'b00);
  endtask

  task automatic t_norm(input logic [31:0] v, input int lz);
    ld(v);
    cpu.w(3'h6, 8'h00);
    lat(lz == 0 ? 3 : (lz + 1) / 2 + 3);
    rq(v << lz);
    cpu.r(3'h6, d);
    chk("overflow", lz == 0, d[6]);
    chk("count", lz, d[4:0]);
  endtask

  task automatic t_abort();
    cpu.w(3'h0, 8'h11);
    cpu.w(3'h6, 8'h05);
    cpu.w(3'h2, 8'h00);
    cpu.idle();
    cf(2'b11);
    cf(2'b01);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cut a hang short
  initial
  begin
    #100000;
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_mul(16'h1234, 16'h00ff);
    t_mul(16'h0012, 16'h0034);
    t_div16(16'hbeef, 16'h0123);
    t_div16(16'h4321, 16'h0000);
    t_div32(32'h12345678, 16'h1234, 1'b0);
    t_div32(32'hfedcba98, 16'h0077, 1'b1);
    t_shift(1'b0, 5'h01);
    t_shift(1'b1, 5'h01);
    t_shift(1'b0, 5'h1f);
    t_shift(1'b1, 5'h10);
    t_norm(32'h00012345, 15);
    t_norm(32'h80000001, 0);
    t_abort();
    give_verdict();
  end
endmodule
